// ===== design/bus_mastership_and_reset_control.sv
// bus mastership arbitration and reset control
// assumes synchronous pins, one clock mclk, an external arbiter driving grant
`timescale 1ns/10ps
`include "bus_ctl_consts.svh"

module bus_mastership_and_reset_control
  import bus_ctl_pkg::*;
(
  input  wire logic                mclk,
  input  wire logic                rst,
  input  wire logic                reset_in_n,
  input  wire logic                high_impedance_in_n,
  input  wire logic                bus_grant_in_n,
  input  wire logic                bus_lock,
  input  wire logic                pin_assign_peripheral_reset_out_n,
  input  wire logic                uart2_rts_n,
  input  wire logic                watchdog_reset,
  input  wire logic                req_valid,
  input  wire access_req_t         req,
  input  wire logic                xfer_done,
  output logic                     req_ready,
  output logic                     bus_request_out_n,
  output logic                     bus_driven_out_n,
  output logic                     transfer_start_n,
  output logic                     bus_oe_n,
  output access_req_t              bus_out,
  output logic                     peripheral_reset_out_n,
  output logic                     master_reset,
  output logic                     normal_reset
);

  // ==========================================================
  // reset handling
  // ==========================================================
  logic                    in_reset;
  logic [`PERIPHERAL_RESET_OUT_N_CNT_W-1:0]  peripheral_reset_out_n_cnt_r;
  logic                    peripheral_reset_out_n_r;
  logic                    master_reset_r;
  logic                    normal_reset_r;

  assign in_reset = ~reset_in_n;

  // the reset pin is taken as synchronous, so its level is simply sampled
  // on every edge; the mode flags follow it one edge later and drop again
  // one edge after the pin is released, which lets the refresh side tell a
  // master reset from a normal one while the pin is still low
  // reset mode chosen by hiz level while reset is held
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      master_reset_r <= 1'b1;
      normal_reset_r <= 1'b0;
    end else begin
      master_reset_r <= in_reset & ~high_impedance_in_n;
      normal_reset_r <= in_reset & high_impedance_in_n;
    end
  end
  assign master_reset = master_reset_r;
  assign normal_reset = normal_reset_r;

  // the stretch counter is reloaded on every cycle of reset or watchdog
  // request, so a long request never shortens the pulse; the counter
  // reaches zero 31 edges after the last request and only then does the
  // shared pin go back to its idle level
  // reset out: one edge after reset in, then 31 clocks stretch
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      peripheral_reset_out_n_r     <= 1'b1;
      peripheral_reset_out_n_cnt_r <= `PERIPHERAL_RESET_OUT_N_CNT_LOAD;
    end else if (in_reset || watchdog_reset) begin
      peripheral_reset_out_n_r     <= 1'b1;
      peripheral_reset_out_n_cnt_r <= `PERIPHERAL_RESET_OUT_N_CNT_LOAD;
    end else if (peripheral_reset_out_n_cnt_r != '0) begin
      peripheral_reset_out_n_r     <= 1'b1;
      peripheral_reset_out_n_cnt_r <= peripheral_reset_out_n_cnt_r - 1'b1;
    end else begin
      peripheral_reset_out_n_r     <= 1'b0;
    end
  end

  // shared pin: reset function forced while reset is active
  assign peripheral_reset_out_n = (peripheral_reset_out_n_r || pin_assign_peripheral_reset_out_n) ? ~peripheral_reset_out_n_r
                                                              : uart2_rts_n;

  // ==========================================================
  // mastership state machine
  // ==========================================================
  master_state_t state_r;
  master_state_t state_nxt;
  logic          granted;
  logic          ts_r;
  logic          br_r;
  logic          bd_r;
  logic          oe_r;

  assign granted = ~bus_grant_in_n;

  // idle: no mastership, implicit: granted but not driving, explicit:
  // driving with no transfer under way, xfer: one access on the bus.
  // a transfer is never cut short by grant loss; the decision to release
  // is only taken once the slave reports completion, so a revoked bus is
  // always left between accesses. the lock keeps explicit ownership even
  // with grant gone, and accesses may still start while it is held
  // next state from grant, pending access and lock
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (granted && (req_valid || bus_lock))
          state_nxt = req_valid ? ST_XFER : ST_EXPLICIT;
        else if (granted)
          state_nxt = ST_IMPLICIT;
      end
      ST_IMPLICIT: begin
        if (!granted)
          state_nxt = ST_IDLE;
        else if (req_valid)
          state_nxt = ST_XFER;
        else if (bus_lock)
          state_nxt = ST_EXPLICIT;
      end
      ST_EXPLICIT: begin
        if (req_valid && (granted || bus_lock))
          state_nxt = ST_XFER;
        else if (!granted && !bus_lock)
          state_nxt = ST_IDLE;
        else if (granted && !bus_lock)
          state_nxt = ST_IMPLICIT;
      end
      ST_XFER: begin
        if (xfer_done) begin
          if (!granted && !bus_lock)
            state_nxt = ST_IDLE;
          else
            state_nxt = ST_EXPLICIT;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // state register, forced idle while reset is in
  always_ff @(posedge mclk or posedge rst) begin
    if (rst)
      state_r <= ST_IDLE;
    else if (in_reset)
      state_r <= ST_IDLE;
    else
      state_r <= state_nxt;
  end

  // req_ready is combinational so the core sees the take in the same
  // cycle; it is masked in reset so no access starts while the bus is
  // being released
  // accept the access on entry to the transfer state
  assign req_ready = (state_r != ST_XFER) && (state_nxt == ST_XFER) && !in_reset;

  // all arbitration outputs are built from the next state and registered,
  // so the pins change only on the rising edge and never glitch; the
  // output enable follows bus-driven exactly, so the bus is three-stated
  // on the same edge as bus-driven is negated
  // registered arbitration outputs
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      br_r <= 1'b0;
      bd_r <= 1'b0;
      oe_r <= 1'b0;
      ts_r <= 1'b0;
    end else if (in_reset) begin
      br_r <= 1'b0;
      bd_r <= 1'b0;
      oe_r <= 1'b0;
      ts_r <= 1'b0;
    end else begin
      br_r <= req_valid && !granted && (state_nxt == ST_IDLE);
      bd_r <= (state_nxt == ST_XFER) || (state_nxt == ST_EXPLICIT);
      oe_r <= (state_nxt == ST_XFER) || (state_nxt == ST_EXPLICIT);
      ts_r <= req_ready;
    end
  end

  // the fields stay on the bus until the next take; they only matter
  // while the output enable is low
  // latch the access driven on the bus
  always_ff @(posedge mclk or posedge rst) begin
    if (rst)
      bus_out <= '0;
    else if (req_ready)
      bus_out <= req;
  end

  assign bus_request_out_n = ~br_r;
  assign bus_driven_out_n  = ~bd_r;
  assign bus_oe_n          = ~oe_r;
  assign transfer_start_n  = ~ts_r;

  // ==========================================================
  // checks
  // ==========================================================
  // cycles since the reset pin was last released, saturating; the hold
  // check uses it to see that reset out is still on during the stretch
  // window, independent of the stretch counter that it guards
  // helper counter for the reset out hold
  logic [`PERIPHERAL_RESET_OUT_N_CNT_W-1:0] low_cnt_r;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst)
      low_cnt_r <= '0;
    else if (in_reset)
      low_cnt_r <= '0;
    else if (low_cnt_r != 6'h3F)
      low_cnt_r <= low_cnt_r + 1'b1;
  end

  a_ts_one_clock: assert property (@(posedge mclk) disable iff (rst)
    !transfer_start_n |=> transfer_start_n) else $error("transfer start too long");
  a_peripheral_reset_out_n_fast: assert property (@(posedge mclk) disable iff (rst)
    in_reset |-> ##[1:2] !peripheral_reset_out_n) else $error("reset out late");
  a_peripheral_reset_out_n_hold: assert property (@(posedge mclk) disable iff (rst)
    (!in_reset && low_cnt_r < 6'h1F) |-> peripheral_reset_out_n_r) else $error("reset out short");
  a_wd_pulse: assert property (@(posedge mclk) disable iff (rst)
    watchdog_reset |=> peripheral_reset_out_n_r [*8]) else $error("watchdog pulse short");
  a_reset_quiet: assert property (@(posedge mclk) disable iff (rst)
    $past(in_reset) |-> (bus_request_out_n && bus_driven_out_n && bus_oe_n))
    else $error("bus not released in reset");
  a_bd_lock_hold: assert property (@(posedge mclk) disable iff (rst)
    (state_r == ST_EXPLICIT && bus_lock && !in_reset) |=> !bus_driven_out_n)
    else $error("locked bus dropped");
  a_idle_release: assert property (@(posedge mclk) disable iff (rst)
    (state_r == ST_EXPLICIT && !bus_lock && !granted && !req_valid) |=> bus_driven_out_n)
    else $error("idle bus not released");
  a_implicit_bd: assert property (@(posedge mclk) disable iff (rst)
    (state_r == ST_IMPLICIT) |-> bus_driven_out_n) else $error("implicit drives bd");
  a_req_drop: assert property (@(posedge mclk) disable iff (rst)
    !transfer_start_n |-> bus_request_out_n) else $error("request held in access");
  a_master_mode: assert property (@(posedge mclk) disable iff (rst)
    (in_reset && !high_impedance_in_n) |=> master_reset) else $error("no master reset");

  // ==========================================================
  // mastership checks
  // ==========================================================

  // a locked owner keeps bus-driven after its transfer ends
  a_lock_keep: assert property (@(posedge mclk) disable iff (rst)
    (state_r == ST_XFER && xfer_done && bus_lock && !in_reset) |=> !bus_driven_out_n)
    else $error("lock lost after transfer");

  // an unfinished transfer keeps the bus driven
  a_xfer_hold: assert property (@(posedge mclk) disable iff (rst)
    (state_r == ST_XFER && !xfer_done && !in_reset) |=> (!bus_driven_out_n && !bus_oe_n))
    else $error("transfer cut short");

  // revoked and unlocked: release on the edge after completion
  a_xfer_release: assert property (@(posedge mclk) disable iff (rst)
    (state_r == ST_XFER && xfer_done && !granted && !bus_lock && !in_reset)
    |=> (bus_driven_out_n && bus_oe_n)) else $error("bus kept after transfer");

  // granted with work or lock: bus-driven comes on
  a_bd_assert: assert property (@(posedge mclk) disable iff (rst)
    (granted && (req_valid || bus_lock) && !in_reset) |=> !bus_driven_out_n)
    else $error("bus-driven missing");

  // pending access without grant raises the request
  a_req_raise: assert property (@(posedge mclk) disable iff (rst)
    (req_valid && !granted && state_r == ST_IDLE && !in_reset) |=> !bus_request_out_n)
    else $error("request not raised");

  // an access is only taken with grant or lock
  a_take_granted: assert property (@(posedge mclk) disable iff (rst)
    req_ready |-> (granted || bus_lock))
    else $error("access taken without grant");

  // transfer start follows the take by one edge
  a_start_follows: assert property (@(posedge mclk) disable iff (rst)
    req_ready |=> !transfer_start_n)
    else $error("transfer start missing");

  // bus enable and bus-driven move together
  a_oe_with_bd: assert property (@(posedge mclk) disable iff (rst)
    bus_oe_n == bus_driven_out_n)
    else $error("enable and bus-driven differ");

  // ==========================================================
  // reset checks
  // ==========================================================

  // cycles since the last watchdog request, saturating
  logic [`PERIPHERAL_RESET_OUT_N_CNT_W-1:0] wd_cnt_r;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst)
      wd_cnt_r <= 6'h3F;
    else if (watchdog_reset)
      wd_cnt_r <= '0;
    else if (wd_cnt_r != 6'h3F)
      wd_cnt_r <= wd_cnt_r + 1'b1;
  end

  // the watchdog pulse lasts the full stretch
  a_wd_hold: assert property (@(posedge mclk) disable iff (rst)
    (wd_cnt_r < `PERIPHERAL_RESET_OUT_N_CNT_LOAD) |-> peripheral_reset_out_n_r)
    else $error("watchdog pulse short");

  // reset without hiz is a normal reset
  a_normal_mode: assert property (@(posedge mclk) disable iff (rst)
    (in_reset && high_impedance_in_n) |=> (normal_reset && !master_reset))
    else $error("no normal reset");

  // the shared pin is reset out while reset is on
  a_pin_reset_fn: assert property (@(posedge mclk) disable iff (rst)
    peripheral_reset_out_n_r |-> !peripheral_reset_out_n)
    else $error("shared pin not reset out");

  // outside reset, with the rts function selected, the pin follows uart2_rts_n
  a_pin_rts: assert property (@(posedge mclk) disable iff (rst)
    (!peripheral_reset_out_n_r && !pin_assign_peripheral_reset_out_n) |-> (peripheral_reset_out_n == uart2_rts_n))
    else $error("shared pin not rts");

  c_xfer: cover property (@(posedge mclk) disable iff (rst) !transfer_start_n);
  c_lock: cover property (@(posedge mclk) disable iff (rst)
    state_r == ST_EXPLICIT && !granted && bus_lock);
  c_implicit: cover property (@(posedge mclk) disable iff (rst) state_r == ST_IMPLICIT);
  c_wdog: cover property (@(posedge mclk) disable iff (rst) watchdog_reset);
  // release after a revoked transfer
  c_release: cover property (@(posedge mclk) disable iff (rst)
    state_r == ST_XFER && xfer_done && !granted && !bus_lock);

endmodule // bus_mastership_and_reset_control

// ===== design/bus_ctl_consts.svh
// constants for the bus mastership and reset control block
// assumes a single 100 MHz system clock
`ifndef BUS_CTL_CONSTS_SVH
`define BUS_CTL_CONSTS_SVH

`define CLK_PERIOD_NS        10
`define PERIPHERAL_RESET_OUT_N_HOLD_CYCLES     31
`define PERIPHERAL_RESET_OUT_N_CNT_W           6
`define PERIPHERAL_RESET_OUT_N_CNT_LOAD        6'h1F
`define TT_W                 2
`define SIZ_W                2
`define ADDR_W               32
`define DATA_W               32

`endif

// ===== design/bus_ctl_pkg.sv
// types for the bus mastership and reset control block
// assumes bus_ctl_consts.svh is on the include path
`include "bus_ctl_consts.svh"
package bus_ctl_pkg;

  // one access request from the core side
  typedef struct packed {
    logic [`ADDR_W-1:0] addr;
    logic [`DATA_W-1:0] wdata;
    logic [`TT_W-1:0]   transfer_type;
    logic [`SIZ_W-1:0]  transfer_size;
    logic               access_mode_info;
    logic               read;
  } access_req_t;

  // mastership state
  typedef enum logic [1:0] {
    ST_IDLE     = 2'b00,
    ST_IMPLICIT = 2'b01,
    ST_EXPLICIT = 2'b10,
    ST_XFER     = 2'b11
  } master_state_t;

endpackage

// ===== verification/arbiter_model.sv
// arbiter and slave model facing the bus mastership block
// assumes one clock mclk and reset rst; the bench steers park, revoke and done_delay
`timescale 1ns/10ps
// ==========================================
// arbiter model
module arbiter_model (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       bus_request_out_n,
  input  wire logic       bus_driven_out_n,
  input  wire logic       transfer_start_n,
  input  wire logic       park,
  input  wire logic       revoke,
  input  wire logic [3:0] done_delay,
  output logic            bus_grant_in_n,
  output logic            xfer_done,
  output logic            other_owner
);
  logic [3:0] wait_r;
  logic       busy_r;
  // grant on request or parking, held until revoked
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bus_grant_in_n <= 1'b1;
    end else begin
      bus_grant_in_n <= revoke | (bus_grant_in_n & bus_request_out_n & ~park);
    end
  end
  // another master moves in only once bus-driven is negated
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      other_owner <= 1'b0;
    end else begin
      other_owner <= revoke & bus_grant_in_n & bus_driven_out_n;
    end
  end
  // slave answers done_delay+1 cycles after a transfer start
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      busy_r    <= 1'b0;
      wait_r    <= 4'h0;
      xfer_done <= 1'b0;
    end else begin
      xfer_done <= 1'b0;
      if (!transfer_start_n) begin
        busy_r <= 1'b1;
        wait_r <= done_delay;
      end else if (busy_r && wait_r == 4'h0) begin
        busy_r    <= 1'b0;
        xfer_done <= 1'b1;
      end else if (busy_r) begin
        wait_r <= wait_r - 4'h1;
      end
    end
  end
endmodule // arbiter_model

// ===== verification/bus_mastership_and_reset_control_bench.sv
// self-checking bench for the bus mastership and reset control block
// assumes the design package and the arbiter model are compiled first
`timescale 1ns/10ps
// ==========================================
// bench top
module bus_mastership_and_reset_control_bench;
  import bus_ctl_pkg::*;
  logic mclk = 0, rst = 1, reset_in_n = 0, high_impedance_in_n = 0, bus_lock = 0;
  logic pin_assign_peripheral_reset_out_n = 1, uart2_rts_n = 1, watchdog_reset = 0, req_valid = 0;
  logic park = 0, revoke = 0, bus_grant_in_n, xfer_done, other_owner, req_ready;
  logic br_n, bd_n, ts_n, oe_n, peripheral_reset_out_n_n, master_reset, normal_reset;
  logic [3:0] done_delay = 4'h1;
  access_req_t req = '0, bus_out;
  int n_errors = 0, checks = 0;
  // clock
  always #5 mclk = ~mclk;
  bus_mastership_and_reset_control bus_mastership_and_reset_control_inst (.mclk(mclk),
    .rst(rst), .reset_in_n(reset_in_n), .high_impedance_in_n(high_impedance_in_n),
    .bus_grant_in_n(bus_grant_in_n), .bus_lock(bus_lock), .pin_assign_peripheral_reset_out_n(pin_assign_peripheral_reset_out_n),
    .uart2_rts_n(uart2_rts_n), .watchdog_reset(watchdog_reset), .req_valid(req_valid),
    .req(req), .xfer_done(xfer_done), .req_ready(req_ready), .bus_request_out_n(br_n),
    .bus_driven_out_n(bd_n), .transfer_start_n(ts_n), .bus_oe_n(oe_n), .bus_out(bus_out),
    .peripheral_reset_out_n(peripheral_reset_out_n_n), .master_reset(master_reset),
    .normal_reset(normal_reset));
  arbiter_model arbiter_model_inst (.mclk(mclk), .rst(rst), .bus_request_out_n(br_n),
    .bus_driven_out_n(bd_n), .transfer_start_n(ts_n), .park(park), .revoke(revoke),
    .done_delay(done_delay), .bus_grant_in_n(bus_grant_in_n), .xfer_done(xfer_done),
    .other_owner(other_owner));
  // compare and count
  task automatic chk(input string what, input logic [74:0] exp, input logic [74:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic close_out();
    if (n_errors == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(negedge mclk);
  endtask
  // one access: optional refused request phase, then start and field checks
  task automatic access(input access_req_t r, input bit no_grant);
    int n;
    n = 0;
    req = r;
    req_valid = 1;
    tick(1);
    if (no_grant) chk("request", 1'b0, br_n);
    while (ts_n !== 1'b0 && n < 50) begin tick(1); n++; end
    req_valid = 0;
    chk("start", 1'b0, ts_n);
    chk("driven", 1'b0, bd_n);
    chk("oe", 1'b0, oe_n);
    chk("fields", r, bus_out);
    chk("req_drop", 1'b1, br_n);
    tick(1);
    chk("start_pulse", 1'b1, ts_n);
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    while (xfer_done !== 1'b1 && n < 50) begin tick(1); n++; end
    tick(1);
  endtask
  // grant withdrawn mid transfer: finish, then release
  task automatic s_revoke_mid();
    done_delay = 4'h5;
    access('{32'h1234_5678, 32'hCAFE_0001, 2'h1, 2'h2, 1'b1, 1'b0}, 1'b0);
    revoke = 1;
    tick(2);
    chk("hold_mid", 1'b0, bd_n);
    wait_done();
    chk("release_bd", 1'b1, bd_n);
    chk("release_oe", 1'b1, oe_n);
    tick(1);
    chk("other_in", 1'b1, other_owner);
    revoke = 0;
  endtask
  // lock keeps explicit mastership, unlock releases at the next edge
  task automatic s_lock();
    park = 1;
    bus_lock = 1;
    tick(3);
    chk("lock_bd", 1'b0, bd_n);
    revoke = 1;
    tick(3);
    chk("lock_keep", 1'b0, bd_n);
    chk("lock_other", 1'b0, other_owner);
    bus_lock = 0;
    tick(1);
    chk("unlock_bd", 1'b1, bd_n);
    chk("unlock_oe", 1'b1, oe_n);
    revoke = 0;
    tick(3);
    chk("implicit", 1'b1, bd_n);
  endtask
  // low pulse length of the reset out pin
  task automatic peripheral_reset_out_n_len(input string what);
    int n;
    n = 0;
    while (peripheral_reset_out_n_n === 1'b0 && n < 80) begin tick(1); n++; end
    chk(what, 1'b1, n >= 31);
  endtask
  task automatic s_pin_reset(input logic hiz_n);
    bus_lock = 1;
    pin_assign_peripheral_reset_out_n = 0;
    tick(2);
    reset_in_n = 0;
    high_impedance_in_n = hiz_n;
    tick(2);
    chk("peripheral_reset_out_n_on", 1'b0, peripheral_reset_out_n_n);
    chk("rst_br", 1'b1, br_n);
    chk("rst_bd", 1'b1, bd_n);
    chk("rst_bus", 2'b11, {oe_n, ts_n});
    chk("master", !hiz_n, master_reset);
    chk("normal", hiz_n, normal_reset);
    bus_lock = 0;
    reset_in_n = 1;
    pin_assign_peripheral_reset_out_n = 1;
    peripheral_reset_out_n_len("peripheral_reset_out_n_hold");
  endtask
  task automatic s_pin_select();
    pin_assign_peripheral_reset_out_n = 0;
    uart2_rts_n = 0;
    tick(1);
    chk("rts_low", 1'b0, peripheral_reset_out_n_n);
    uart2_rts_n = 1;
    tick(1);
    chk("rts_high", 1'b1, peripheral_reset_out_n_n);
    pin_assign_peripheral_reset_out_n = 1;
    watchdog_reset = 1;
    tick(1);
    watchdog_reset = 0;
    tick(1);
    peripheral_reset_out_n_len("wdog_hold");
  endtask
  // main sequence
  initial begin
    tick(2);
    rst = 0;
    tick(1);
    chk("por_master", 1'b1, master_reset);
    reset_in_n = 1;
    high_impedance_in_n = 1;
    tick(40);
    access('{32'hA5A5_0000, 32'h0000_00FF, 2'h0, 2'h1, 1'b0, 1'b1}, 1'b1);
    wait_done();
    s_revoke_mid();
    s_lock();
    s_pin_reset(1'b0);
    s_pin_reset(1'b1);
    s_pin_select();
    close_out();
  end
  // watchdog against hangs
  initial begin
    #20000;
    n_errors++;
    close_out();
  end
endmodule // bus_mastership_and_reset_control_bench
